// ==== hw/stms_core.sv ====
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
// How it works
// - three inputs each get gain 0..1000.0 % and bias -100..100 %, writable while running.
// - full-scale input maps to 100 percent times gain of max frequency or rated torque.
// - minimum input (0 V or 4 mA) maps to the bias level.
// - switching enabled only when a digital input has function code 71.
// - switching input off gives speed control, on gives torque control.
// - control select 0 is speed control, 1 is torque control.
// - control select changes refused while running.
// - mode change follows either input edge after 0 to 1000 ms delay.
// - delay applies only when function code 71 is assigned.
// - all three analog values freeze during the delay.
// - speed mode uses reference source, torque mode uses speed-limit source.
// - frequency reference and speed limit may share terminal 13 or 14.
// - torque-reference terminal is a torque limit in speed control.
// - torque-reference terminal is the torque reference in torque control.
// - in speed control, effective torque limit is the smaller of abs analog and parameter.
// - run off in speed control decelerates to stop.
// - run off in torque control drops to speed control then decelerates.
// - code 13 means torque reference, code 14 torque compensation on the other terminal.
module stms_core
   import stms_pkg::*;
#(
   parameter int ADC_W = STMS_ADC_W
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [STMS_NUM_DI-1:0] dig_in,
   input wire logic run_cmd,
   input wire logic [STMS_NUM_AI*ADC_W-1:0] ai_frac,
   input wire logic [1:0] ref_src_sel,
   input wire logic [1:0] spd_lim_sel,
   output logic torque_mode,
   output logic decel_stop,
   output logic signed [15:0] freq_ref,
   output logic signed [15:0] speed_limit,
   output logic signed [15:0] torque_ref,
   output logic signed [15:0] torque_comp,
   output logic [15:0] torque_limit
);
   // elaboration check: scaling keeps the top 16 bits of a 16 by ADC_W product
   if (ADC_W < 4 || ADC_W > 16) begin : g_bad_adc_w
      $error("ADC_W out of range");
   end

   localparam int DLY_W = 28;
   localparam logic [DLY_W-1:0] CYC_MS = DLY_W'(STMS_CYC_PER_MS);

   // software settings
   logic ctrl_sel_q;
   logic [15:0] dly_ms_q;
   logic [47:0] difn_q;
   logic [15:0] gain_q [STMS_NUM_AI];
   logic signed [15:0] bias_q [STMS_NUM_AI];
   logic [23:0] aifn_q;
   logic [15:0] fwd_cap_q, rev_cap_q;
   stms_bus_t bus;
   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // runtime state
   stms_mode_t mode_q, mode_d;
   logic sw_in_q;
   logic hold_q;
   logic [DLY_W-1:0] hold_cnt_q;
   logic [15:0] ms_cnt_q;
   logic running_q;
   logic [ADC_W-1:0] ai_hold_q [STMS_NUM_AI];

   // switching function assigned on any digital input
   logic [STMS_NUM_DI-1:0] fn_hit;
   genvar gi;
   generate
      for (gi = 0; gi < STMS_NUM_DI; gi++) begin : g_di
         assign fn_hit[gi] = (difn_q[gi*8 +: 8] == STMS_FN_SWITCH);
      end
   endgenerate
   wire sw_en = |fn_hit;
   wire sw_level = |(fn_hit & dig_in);
   wire sw_edge = sw_en && (sw_level != sw_in_q);
   wire want_torque = sw_en ? sw_level : ctrl_sel_q;
   wire hold_done = (ms_cnt_q >= dly_ms_q); // a delay shortened mid-hold still ends it

   // clamp helpers for settings writes
   wire [15:0] gain_wr = (reg_wdata[15:0] > STMS_GAIN_MAX) ? STMS_GAIN_MAX : reg_wdata[15:0];
   wire signed [15:0] bias_raw = reg_wdata[15:0];
   wire signed [15:0] bias_wr = (bias_raw > STMS_BIAS_MAX) ? STMS_BIAS_MAX :
                                (bias_raw < STMS_BIAS_MIN) ? STMS_BIAS_MIN : bias_raw;
   wire [15:0] dly_wr = (reg_wdata[15:0] > 16'(STMS_DELAY_MAX_MS)) ? 16'(STMS_DELAY_MAX_MS) : reg_wdata[15:0];

   // register writes; gain and bias accepted at any time
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_sel_q <= 1'b0;
         dly_ms_q <= 16'h0000;
         difn_q <= 48'h0;
         aifn_q <= 24'h0;
         fwd_cap_q <= STMS_TCAP_RST;
         rev_cap_q <= STMS_TCAP_RST;
         for (int i = 0; i < STMS_NUM_AI; i++) begin
            gain_q[i] <= STMS_GAIN_RST;
            bias_q[i] <= STMS_BIAS_RST;
         end
      end else if (bus.wr) begin
         if (bus.addr == STMS_R_CTRL && !running_q) ctrl_sel_q <= bus.wdata[0];
         if (bus.addr == STMS_R_DELAY) dly_ms_q <= dly_wr;
         if (bus.addr == STMS_R_DIFN) difn_q[31:0] <= bus.wdata;
         if (bus.addr == STMS_R_DIFN2) difn_q[47:32] <= bus.wdata[15:0];
         if (bus.addr == STMS_R_AIFN) aifn_q <= bus.wdata[23:0];
         if (bus.addr == STMS_R_TCAP) begin
            fwd_cap_q <= bus.wdata[15:0];
            rev_cap_q <= bus.wdata[31:16];
         end
         for (int i = 0; i < STMS_NUM_AI; i++) begin
            if (bus.addr == STMS_R_GAIN0 + 8'(8*i)) gain_q[i] <= gain_wr;
            if (bus.addr == STMS_R_BIAS0 + 8'(8*i)) bias_q[i] <= bias_wr;
         end
      end
   end

   // mode sequencing with hold timer
   always_comb begin
      mode_d = mode_q;
      if (!run_cmd) mode_d = STMS_SPEED;
      else if (!hold_q && !sw_edge) mode_d = want_torque ? STMS_TORQUE : STMS_SPEED;
      else if (hold_q && hold_done) mode_d = want_torque ? STMS_TORQUE : STMS_SPEED;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         mode_q <= STMS_SPEED;
         sw_in_q <= 1'b0;
         hold_q <= 1'b0;
         hold_cnt_q <= '0;
         ms_cnt_q <= 16'h0000;
         running_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         sw_in_q <= sw_level;
         running_q <= run_cmd;
         if (sw_edge && dly_ms_q != 16'h0000) begin
            hold_q <= 1'b1;
            hold_cnt_q <= '0;
            ms_cnt_q <= 16'h0000;
         end else if (hold_q) begin
            if (hold_done) hold_q <= 1'b0;
            else if (hold_cnt_q == CYC_MS - 1'b1) begin
               hold_cnt_q <= '0;
               ms_cnt_q <= ms_cnt_q + 16'h0001;
            end else hold_cnt_q <= hold_cnt_q + 1'b1;
         end
      end
   end

   // analog sample hold and scaling per input
   logic signed [15:0] scaled [STMS_NUM_AI];
   generate
      for (gi = 0; gi < STMS_NUM_AI; gi++) begin : g_ai
         wire [ADC_W-1:0] raw = ai_frac[gi*ADC_W +: ADC_W];
         always_ff @(posedge core_clk) begin
            if (reset) ai_hold_q[gi] <= '0;
            else if (!hold_q) ai_hold_q[gi] <= raw;
         end
         // bias + gain * fraction, fraction = raw / full scale
         wire [ADC_W-1:0] use_v = hold_q ? ai_hold_q[gi] : raw;
         wire [ADC_W+15:0] prod = gain_q[gi] * use_v;
         wire signed [31:0] sum = 32'(signed'({1'b0, prod[ADC_W+15:ADC_W]})) + 32'(bias_q[gi]);
         assign scaled[gi] = (sum > 32'sd32767) ? 16'sh7FFF : (sum < -32'sd32768) ? -16'sh8000 : 16'(sum);
      end
   endgenerate

   // terminal roles: input 0 is terminal 13, 1 is terminal 16, 2 is terminal 14
   wire tref_t16 = (aifn_q[15:8] == STMS_FN_TREF);
   wire tref_t14 = (aifn_q[23:16] == STMS_FN_TREF) && !tref_t16;
   wire comp_t16 = (aifn_q[15:8] == STMS_FN_TCOMP) && !tref_t16;
   wire comp_t14 = (aifn_q[23:16] == STMS_FN_TCOMP) && !tref_t14;
   wire signed [15:0] tref_val = tref_t16 ? scaled[1] : scaled[2];
   wire tref_any = tref_t16 | tref_t14;
   wire is_torque = (mode_q == STMS_TORQUE);
   wire [15:0] tref_abs = tref_val[15] ? 16'(-tref_val) : 16'(tref_val);
   wire [15:0] par_cap = (fwd_cap_q < rev_cap_q) ? fwd_cap_q : rev_cap_q;
   wire [15:0] lim_d = (tref_any && !is_torque && tref_abs < par_cap) ? tref_abs : par_cap;
   // shared-terminal source select: 0 terminal 13, 1 terminal 14, else zero
   wire signed [15:0] fsrc = (ref_src_sel == 2'd0) ? scaled[0] : (ref_src_sel == 2'd1) ? scaled[2] : 16'sh0000;
   wire signed [15:0] lsrc = (spd_lim_sel == 2'd0) ? scaled[0] : (spd_lim_sel == 2'd1) ? scaled[2] : 16'sh0000;

   // registered outputs and bus read
   always_ff @(posedge core_clk) begin
      if (reset) begin
         torque_mode <= 1'b0;
         decel_stop <= 1'b0;
         freq_ref <= 16'sh0000;
         speed_limit <= 16'sh0000;
         torque_ref <= 16'sh0000;
         torque_comp <= 16'sh0000;
         torque_limit <= STMS_TCAP_RST;
         reg_rdata <= 32'h0;
      end else begin
         torque_mode <= is_torque;
         decel_stop <= !run_cmd && (running_q || decel_stop);
         freq_ref <= is_torque ? 16'sh0000 : fsrc;
         speed_limit <= is_torque ? lsrc : 16'sh0000;
         torque_ref <= (is_torque && tref_any) ? tref_val : 16'sh0000;
         torque_comp <= comp_t16 ? scaled[1] : comp_t14 ? scaled[2] : 16'sh0000;
         torque_limit <= lim_d;
         reg_rdata <= 32'h0;
         if (bus.rd) begin
            case (bus.addr)
               STMS_R_CTRL: reg_rdata <= {31'h0, ctrl_sel_q};
               STMS_R_DELAY: reg_rdata <= {16'h0, dly_ms_q};
               STMS_R_DIFN: reg_rdata <= difn_q[31:0];
               STMS_R_DIFN2: reg_rdata <= {16'h0, difn_q[47:32]};
               STMS_R_GAIN0: reg_rdata <= {16'h0, gain_q[0]};
               STMS_R_BIAS0: reg_rdata <= {16'h0, bias_q[0]};
               STMS_R_GAIN0 + 8'h08: reg_rdata <= {16'h0, gain_q[1]};
               STMS_R_BIAS0 + 8'h08: reg_rdata <= {16'h0, bias_q[1]};
               STMS_R_GAIN0 + 8'h10: reg_rdata <= {16'h0, gain_q[2]};
               STMS_R_BIAS0 + 8'h10: reg_rdata <= {16'h0, bias_q[2]};
               STMS_R_AIFN: reg_rdata <= {8'h0, aifn_q};
               STMS_R_TCAP: reg_rdata <= {rev_cap_q, fwd_cap_q};
               STMS_R_STAT: reg_rdata <= {28'h0, running_q, hold_q, sw_en, is_torque};
               default: reg_rdata <= 32'h0;
            endcase
         end
      end
   end

   // checks
   property p_sel_locked;
      @(posedge core_clk) disable iff (reset) (running_q && bus.wr && bus.addr == STMS_R_CTRL) |=> $stable(ctrl_sel_q);
   endproperty
   a_sel_locked: assert property (p_sel_locked) else $error("control select changed while running");
   property p_stop_speed;
      @(posedge core_clk) disable iff (reset) !run_cmd |=> !is_torque;
   endproperty
   a_stop_speed: assert property (p_stop_speed) else $error("torque mode kept with run off");
   property p_hold_freeze;
      @(posedge core_clk) disable iff (reset) hold_q |=> hold_q |->
         $stable(ai_hold_q[0]) && $stable(ai_hold_q[1]) && $stable(ai_hold_q[2]);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("analog value moved during hold");
   property p_no_hold_unassigned;
      @(posedge core_clk) disable iff (reset) !sw_en && !hold_q |=> !hold_q;
   endproperty
   a_no_hold_unassigned: assert property (p_no_hold_unassigned) else $error("hold started without switch function");
   property p_limit_min;
      @(posedge core_clk) disable iff (reset) 1'b1 |=> torque_limit <= $past(par_cap);
   endproperty
   a_limit_min: assert property (p_limit_min) else $error("torque limit above parameter cap");
   property p_gain_range;
      @(posedge core_clk) disable iff (reset) gain_q[0] <= STMS_GAIN_MAX;
   endproperty
   a_gain_range: assert property (p_gain_range) else $error("gain out of range");
   property p_tref_speed;
      @(posedge core_clk) disable iff (reset) !is_torque |=> torque_ref == 16'sh0000;
   endproperty
   a_tref_speed: assert property (p_tref_speed) else $error("torque reference driven in speed control");
   property p_mode_follow;
      @(posedge core_clk) disable iff (reset) (run_cmd && sw_en && !hold_q && !sw_edge) |=> is_torque == $past(sw_level);
   endproperty
   a_mode_follow: assert property (p_mode_follow) else $error("mode does not follow switch input");
   // switching steps: an input edge, then a settled cycle
   sequence s_edge_now;
      run_cmd && sw_edge && !hold_q && dly_ms_q == 16'h0000;
   endsequence
   sequence s_settled;
      run_cmd && sw_en && !hold_q && !sw_edge;
   endsequence
   property p_zero_delay;
      @(posedge core_clk) disable iff (reset) s_edge_now ##1 s_settled |=> is_torque == $past(sw_level);
   endproperty
   a_zero_delay: assert property (p_zero_delay) else $error("zero delay switch not applied");
   property p_hold_keeps_mode;
      @(posedge core_clk) disable iff (reset) (run_cmd && hold_q && !hold_done) |=> $stable(mode_q);
   endproperty
   a_hold_keeps_mode: assert property (p_hold_keeps_mode) else $error("mode changed during hold");
   property p_hold_start;
      @(posedge core_clk) disable iff (reset) (sw_edge && dly_ms_q != 16'h0000) |=> hold_q;
   endproperty
   a_hold_start: assert property (p_hold_start) else $error("hold not started");
   property p_hold_capture;
      @(posedge core_clk) disable iff (reset) (sw_edge && !hold_q && dly_ms_q != 16'h0000) |=>
         ai_hold_q[0] == $past(ai_frac[ADC_W-1:0]);
   endproperty
   a_hold_capture: assert property (p_hold_capture) else $error("value not captured at edge");
   property p_decel;
      @(posedge core_clk) disable iff (reset) (running_q && !run_cmd) |=> decel_stop;
   endproperty
   a_decel: assert property (p_decel) else $error("no stop after run command dropped");
   property p_limit_analog;
      @(posedge core_clk) disable iff (reset) (tref_any && !is_torque) |=> torque_limit <= $past(tref_abs);
   endproperty
   a_limit_analog: assert property (p_limit_analog) else $error("limit above analog input");
   property p_tref_torque;
      @(posedge core_clk) disable iff (reset) (is_torque && tref_any) |=> torque_ref == $past(tref_val);
   endproperty
   a_tref_torque: assert property (p_tref_torque) else $error("torque reference not passed");
endmodule

// ==== pkg/stms_pkg.sv ====
package stms_pkg;
   // scaling: percent settings are stored in tenths of a percent
   localparam int STMS_ADC_W = 12;                // normalized input width
   localparam int STMS_VAL_W = 16;                // signed scaled value, 0.1 % units
   localparam logic [15:0] STMS_GAIN_MAX = 16'h2710;   // 1000.0 %
   localparam logic signed [15:0] STMS_BIAS_MAX = 16'sh03E8; // 100.0 %
   localparam logic signed [15:0] STMS_BIAS_MIN = -16'sh03E8; // -100.0 %
   localparam logic [15:0] STMS_GAIN_RST = 16'h03E8;   // 100.0 %
   localparam logic signed [15:0] STMS_BIAS_RST = 16'sh0000;
   localparam logic [15:0] STMS_TCAP_RST = 16'h07D0;   // 200.0 %
   // function codes
   localparam logic [7:0] STMS_FN_SWITCH = 8'h47;  // digital input code 71
   localparam logic [7:0] STMS_FN_TREF = 8'h13;    // analog code 13 (hex as set)
   localparam logic [7:0] STMS_FN_TCOMP = 8'h14;   // analog code 14 (hex as set)
   localparam int STMS_NUM_DI = 6;
   localparam int STMS_NUM_AI = 3;
   // hold delay
   localparam int STMS_DELAY_MAX_MS = 1000;
   localparam int STMS_CLK_MHZ = 250;
   localparam int STMS_CYC_PER_MS = STMS_CLK_MHZ * 1000;
   // register map (word index = byte address / 4)
   localparam logic [7:0] STMS_R_CTRL = 8'h00;     // bit0 control_select
   localparam logic [7:0] STMS_R_DELAY = 8'h04;    // switch_hold_delay in ms
   localparam logic [7:0] STMS_R_DIFN = 8'h08;     // inputs 1..4 function codes, 8 bits each
   localparam logic [7:0] STMS_R_GAIN0 = 8'h10;    // gain, per input +8*i
   localparam logic [7:0] STMS_R_BIAS0 = 8'h14;    // bias, per input +8*i
   localparam logic [7:0] STMS_R_AIFN = 8'h28;     // analog function codes, 8 bits each
   localparam logic [7:0] STMS_R_TCAP = 8'h2C;     // [15:0] forward cap, [31:16] reverse regen cap
   localparam logic [7:0] STMS_R_STAT = 8'h30;     // status
   localparam logic [7:0] STMS_R_DIFN2 = 8'h0C;    // inputs 5..6 function codes
   // control modes
   typedef enum logic [1:0] {
      STMS_SPEED = 2'b01,
      STMS_TORQUE = 2'b10
   } stms_mode_t;
   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } stms_bus_t;
endpackage

// ==== test/stms_host_model.sv ====
`timescale 1ns/100ps
// host side: digital levels, run command, analog fractions and source selects
module stms_host_model
   import stms_pkg::*;
(
   input wire logic core_clk,
   output logic [STMS_NUM_DI-1:0] dig_in,
   output logic run_cmd,
   output logic [STMS_NUM_AI*STMS_ADC_W-1:0] ai_frac,
   output logic [1:0] ref_src_sel,
   output logic [1:0] spd_lim_sel
);
   logic [STMS_ADC_W-1:0] ai_q [STMS_NUM_AI];
   // packing order: [0] terminal 13, [1] terminal 16, [2] terminal 14
   assign ai_frac = {ai_q[2], ai_q[1], ai_q[0]};
   // idle levels from time zero: stopped, all inputs off
   initial begin
      dig_in = '0;
      run_cmd = 1'b0;
      ref_src_sel = 2'd0;
      spd_lim_sel = 2'd0;
      foreach (ai_q[i]) ai_q[i] = '0;
   end
   // each level change lands just after a rising edge
   task automatic set_di(input logic [STMS_NUM_DI-1:0] v);
      @(posedge core_clk) dig_in <= v;
   endtask
   task automatic set_run(input logic v);
      @(posedge core_clk) run_cmd <= v;
   endtask
   task automatic set_ai(input int idx, input logic [STMS_ADC_W-1:0] v);
      @(posedge core_clk) ai_q[idx] <= v;
   endtask
   task automatic set_sel(input logic [1:0] r, input logic [1:0] s);
      @(posedge core_clk) ref_src_sel <= r;
      spd_lim_sel <= s;
   endtask
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   import stms_pkg::*;
   typedef struct {int sel; logic [31:0] exp;} stms_note_t;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [STMS_NUM_DI-1:0] dig_in;
   logic run_cmd, torque_mode, decel_stop;
   logic [STMS_NUM_AI*STMS_ADC_W-1:0] ai_frac;
   logic [1:0] ref_src_sel, spd_lim_sel;
   logic signed [15:0] freq_ref, speed_limit, torque_ref, torque_comp;
   logic [15:0] torque_limit;
   logic rd_q = 1'b0;
   logic pchk = 1'b0;
   stms_note_t notes [$];
   int n_mismatch = 0;
   int checks = 0;
   int raw, g_r, b_r;
   logic [1:0] sel_r;
   string names [8] = '{"reg_rdata", "torque_mode", "decel_stop", "freq_ref", "speed_limit", "torque_ref",
      "torque_limit", "torque_comp"};
   // 250 MHz core clock
   always #2 core_clk = ~core_clk;
   stms_host_model stms_host_model_inst (.core_clk(core_clk), .dig_in(dig_in), .run_cmd(run_cmd),
      .ai_frac(ai_frac), .ref_src_sel(ref_src_sel), .spd_lim_sel(spd_lim_sel));
   stms_core stms_core_inst (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dig_in(dig_in), .run_cmd(run_cmd),
      .ai_frac(ai_frac), .ref_src_sel(ref_src_sel), .spd_lim_sel(spd_lim_sel), .torque_mode(torque_mode),
      .decel_stop(decel_stop), .freq_ref(freq_ref), .speed_limit(speed_limit), .torque_ref(torque_ref),
      .torque_comp(torque_comp), .torque_limit(torque_limit));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   function automatic logic [31:0] got(input int sel);
      case (sel)
         0: return reg_rdata;
         1: return {31'h0, torque_mode};
         2: return {31'h0, decel_stop};
         3: return {16'h0, freq_ref};
         4: return {16'h0, speed_limit};
         5: return {16'h0, torque_ref};
         6: return {16'h0, torque_limit};
         default: return {16'h0, torque_comp};
      endcase
   endfunction
   task automatic pop_cmp;
      stms_note_t n;
      if (notes.size() == 0) begin
         check("note_queue", 32'h0, 32'h1);
         return;
      end
      n = notes.pop_front();
      check(names[n.sel], got(n.sel), n.exp);
   endtask
   // monitor: read data in the cycle after the strobe, port checks when flagged
   always @(posedge core_clk) begin
      if (rd_q) pop_cmp();
      if (pchk) pop_cmp();
      rd_q <= reg_rd;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic do_reset;
      @(posedge core_clk) reset <= 1'b1;
      idle(16);
      reset <= 1'b0;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk) reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk) reg_wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk) reg_addr <= a;
      reg_rd <= 1'b1;
      notes.push_back('{0, e});
      @(posedge core_clk) reg_rd <= 1'b0;
   endtask
   task automatic expect_port(input int sel, input logic [15:0] e);
      @(posedge core_clk) pchk <= 1'b1;
      notes.push_back('{sel, {16'h0, e}});
      @(posedge core_clk) pchk <= 1'b0;
   endtask
   function automatic logic [15:0] scl(input int g, input int b, input int r);
      return 16'(b + ((g * r) >>> 12));
   endfunction
   // watchdog well beyond the expected run length
   initial begin
      idle(5000);
      n_mismatch++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      void'($urandom(32'h918C));
      do_reset();
      expect_port(6, 16'h07D0);
      stms_host_model_inst.set_run(1'b1);
      stms_host_model_inst.set_di(6'($urandom));
      idle(4);
      expect_port(1, 16'h0);
      bus_rd(STMS_R_STAT, 32'h8);
      bus_wr(STMS_R_CTRL, 32'h1);
      bus_rd(STMS_R_CTRL, 32'h0);
      stms_host_model_inst.set_run(1'b0);
      idle(2);
      bus_wr(STMS_R_CTRL, 32'h1);
      bus_rd(STMS_R_CTRL, 32'h1);
      stms_host_model_inst.set_run(1'b1);
      idle(4);
      expect_port(1, 16'h1);
      stms_host_model_inst.set_run(1'b0);
      idle(2);
      bus_wr(STMS_R_CTRL, 32'h0);
      // scaling with settings changed while running, first sample at minimum input
      stms_host_model_inst.set_run(1'b1);
      stms_host_model_inst.set_di(6'h00);
      for (int i = 0; i < 6; i++) begin
         raw = (i == 0) ? 0 : $urandom % 4096;
         g_r = (i == 0) ? 1500 : $urandom % 10001;
         b_r = (i == 0) ? -200 : int'($urandom % 2001) - 1000;
         bus_wr(STMS_R_GAIN0, 32'(g_r));
         bus_wr(STMS_R_BIAS0, 32'(b_r));
         stms_host_model_inst.set_ai(0, raw[11:0]);
         idle(4);
         expect_port(3, scl(g_r, b_r, raw));
      end
      bus_wr(STMS_R_GAIN0, 32'h0000FFFF);
      bus_rd(STMS_R_GAIN0, 32'h00002710);
      bus_wr(STMS_R_BIAS0, 32'hFFFFF000);
      stms_host_model_inst.set_ai(0, 12'h000);
      idle(4);
      expect_port(3, 16'hFC18);
      // torque reference terminal acting as a limit in speed control
      bus_wr(STMS_R_AIFN, 32'h00001300);
      bus_wr(STMS_R_TCAP, {16'd600, 16'd700});
      stms_host_model_inst.set_ai(1, 12'hFFF);
      idle(4);
      expect_port(6, 16'd600);
      stms_host_model_inst.set_ai(1, 12'h400);
      idle(4);
      expect_port(6, 16'd250);
      // input-driven switching with zero delay, shared terminal 14
      bus_wr(STMS_R_DIFN, {24'h0, STMS_FN_SWITCH});
      sel_r = 2'($urandom);
      stms_host_model_inst.set_sel(2'd1, sel_r);
      stms_host_model_inst.set_ai(2, 12'h800);
      idle(4);
      expect_port(3, 16'd500);
      stms_host_model_inst.set_di({5'($urandom), 1'b1});
      idle(3);
      expect_port(1, 16'h1);
      expect_port(5, 16'd250);
      expect_port(4, (sel_r == 2'd0) ? 16'hFC18 : (sel_r == 2'd1) ? 16'd500 : 16'h0000);
      expect_port(7, 16'h0000);
      bus_wr(STMS_R_AIFN, 32'h00141300);
      idle(2);
      expect_port(7, 16'd500);
      stms_host_model_inst.set_di({5'($urandom), 1'b0});
      idle(3);
      expect_port(1, 16'h0);
      stms_host_model_inst.set_di({5'($urandom), 1'b1});
      idle(3);
      stms_host_model_inst.set_run(1'b0);
      idle(3);
      expect_port(1, 16'h0);
      expect_port(2, 16'h1);
      stms_host_model_inst.set_run(1'b1);
      stms_host_model_inst.set_di({5'($urandom), 1'b0});
      idle(3);
      expect_port(2, 16'h0);
      stms_host_model_inst.set_run(1'b0);
      idle(3);
      expect_port(2, 16'h1);
      // nonzero delay: mode held and analog values frozen
      stms_host_model_inst.set_run(1'b1);
      bus_wr(STMS_R_DELAY, 32'd1);
      idle(3);
      stms_host_model_inst.set_di({5'($urandom), 1'b1});
      idle(3);
      stms_host_model_inst.set_ai(2, 12'hFFF);
      idle(100);
      expect_port(1, 16'h0);
      expect_port(3, 16'd500);
      bus_rd(STMS_R_STAT, 32'hE);
      do_reset();
      expect_port(6, 16'h07D0);
      bus_rd(8'h40, 32'h0);
      idle(2);
      tally_and_finish();
   end
endmodule
